// ---- design/ccdiv_pkg.sv ----
// Package of register map, field layout and encodings for the channel 3 and input divider control
package ccdiv_pkg;
  localparam int ADDR_W = 10;
  localparam logic [ADDR_W-1:0] ADDR_IN_CTRL = 10'h01e;
  localparam logic [ADDR_W-1:0] ADDR_CH_CYCLES = 10'h199;
  localparam logic [ADDR_W-1:0] ADDR_CH_CTRL = 10'h19a;
  localparam logic [ADDR_W-1:0] ADDR_CH_PWR = 10'h19b;
  localparam logic [ADDR_W-1:0] ADDR_IN_RATIO = 10'h1e0;
  localparam logic [ADDR_W-1:0] ADDR_IN_SEL = 10'h1e1;
  localparam logic [ADDR_W-1:0] ADDR_UPDATE = 10'h232;
  localparam logic [7:0] RST_ZERO = 8'h00;
  // Channel control fields
  localparam int CH_BYPASS_B = 7;
  localparam int CH_IGN_ALIGN_B = 6;
  localparam int CH_FORCE_B = 5;
  localparam int CH_START_HI_B = 4;
  localparam int CH_PHASE_LSB = 0;
  localparam int PHASE_W = 4;
  // Channel power and routing fields
  localparam int CH_PD_B = 2;
  localparam int CH_DIRECT_B = 1;
  localparam int CH_DCC_OFF_B = 0;
  localparam logic [7:0] CH_PWR_MASK = 8'h07;
  // Channel cycles fields
  localparam int CYC_LO_LSB = 4;
  localparam int CYC_HI_LSB = 0;
  // Input control fields
  localparam int IN_PD_ALL_B = 4;
  localparam int IN_PD_OSC_IF_B = 3;
  localparam int IN_PD_SRC_B = 2;
  localparam int IN_SEL_OSC_B = 1;
  localparam int IN_BYPASS_B = 0;
  localparam logic [7:0] IN_CTRL_MASK = 8'h1f;
  localparam logic [7:0] RATIO_MASK = 8'h07;
  localparam logic [7:0] SEL_MASK = 8'h03;
  localparam int UPDATE_B = 0;
  // Input select field
  localparam logic [1:0] SEL_EXT = 2'h0;
  localparam logic [1:0] SEL_DIV_ONLY = 2'h1;
  localparam logic [1:0] SEL_OSC = 2'h2;
  // Input divider ratio codes
  localparam logic [2:0] RATIO_DIV2 = 3'h0;
  localparam logic [2:0] RATIO_DIV3 = 3'h1;
  localparam logic [2:0] RATIO_DIV4 = 3'h2;
  localparam logic [2:0] RATIO_DIV5 = 3'h3;
  localparam logic [2:0] RATIO_DIV6 = 3'h4;
  localparam logic [2:0] RATIO_BYPASS = 3'h6;
  // High/low counts minus one for each ratio
  localparam logic [3:0] CNT_0 = 4'h0;
  localparam logic [3:0] CNT_1 = 4'h1;
  localparam logic [3:0] CNT_2 = 4'h2;
  typedef enum logic [2:0] {
    CCDIV_RUN = 3'b001,
    CCDIV_HOLD = 3'b010,
    CCDIV_STATIC = 3'b100
  } ccdiv_mode_t;
endpackage : ccdiv_pkg

// ---- design/ccdiv_counter.sv ----
// Programmable high/low divider with start level and phase delay, stepped by an input tick
`timescale 1ns/100ps
module ccdiv_counter
  import ccdiv_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Control
  input wire logic tick,
  input wire logic hold,
  input wire logic start_hi,
  input wire logic [PHASE_W-1:0] delay,
  input wire logic [3:0] hi_m1,
  input wire logic [3:0] lo_m1,
  // Divided level
  output logic level_r
);
  logic [PHASE_W-1:0] phase_r;
  logic [3:0] cnt_r;
  logic [3:0] limit;

  assign limit = level_r ? hi_m1 : lo_m1;

  always_ff @(posedge clk) begin
    if (srst) begin
      level_r <= 1'b0;
      phase_r <= '0;
      cnt_r <= CNT_0;
    end else if (hold) begin
      // Held: preset so the first tick after release starts the delayed sequence
      level_r <= start_hi;
      phase_r <= delay;
      cnt_r <= CNT_0;
    end else if (tick) begin
      if (phase_r != '0) begin
        phase_r <= phase_r - 1'b1;
      end else if (cnt_r >= limit) begin
        level_r <= ~level_r;
        cnt_r <= CNT_0;
      end else begin
        cnt_r <= cnt_r + 1'b1;
      end
    end
  end
endmodule : ccdiv_counter

// ---- design/ccdiv_ctrl.sv ----
// Channel 3 divider and shared input divider control with buffered registers and update strobe
`timescale 1ns/100ps
module ccdiv_ctrl
  import ccdiv_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Clock source pins, asynchronous
  input wire logic ext_clk_pin,
  input wire logic osc_clk_pin,
  // Chip-level alignment pin, active low, asynchronous
  input wire logic align_n_pin,
  // Driver polarity reversal, same clock domain
  input wire logic drv_invert,
  // Channel outputs
  output logic channel3_output_a,
  output logic channel3_output_b,
  output logic channel3_output_c,
  output logic channel3_pd,
  output logic duty_cycle_correction,
  output logic channel3_div_pd,
  // Input section power status
  output logic clk_in_section_pd,
  output logic osc_if_pd,
  output logic osc_and_clk_pd
);
  // Buffered and active register copies
  logic [7:0] buf_in_ctrl_r;
  logic [7:0] buf_ch_cyc_r;
  logic [7:0] buf_ch_ctrl_r;
  logic [7:0] buf_ch_pwr_r;
  logic [7:0] buf_ratio_r;
  logic [7:0] buf_sel_r;
  logic [7:0] act_in_ctrl_r;
  logic [7:0] act_ch_cyc_r;
  logic [7:0] act_ch_ctrl_r;
  logic [7:0] act_ch_pwr_r;
  logic [7:0] act_ratio_r;
  logic [7:0] act_sel_r;
  logic update_r;

  // Synchronisers
  logic ext_s1_r;
  logic ext_s2_r;
  logic ext_d_r;
  logic osc_s1_r;
  logic osc_s2_r;
  logic osc_d_r;
  logic align_s1_r;
  logic align_s2_r;

  // Derived controls
  logic sel_osc;
  logic in_bypass;
  logic in_pd;
  logic src_level;
  logic src_tick;
  logic [2:0] ratio;
  logic ratio_static;
  logic [3:0] in_hi_m1;
  logic [3:0] in_lo_m1;
  logic in_div_level;
  logic div_in_level;
  logic div_in_d_r;
  logic ch_tick;
  logic ch_bypass;
  logic ch_ign;
  logic ch_force;
  logic ch_start;
  logic ch_pd;
  logic ch_direct;
  logic align_act;
  logic ch_hold;
  logic ch_div_level;
  logic direct_active;
  logic direct_level;
  logic out_nxt;
  ccdiv_mode_t mode;

  // Register writes land in the buffers; strobe write is remembered for one cycle
  always_ff @(posedge clk) begin
    if (srst) begin
      buf_in_ctrl_r <= RST_ZERO;
      buf_ch_cyc_r <= RST_ZERO;
      buf_ch_ctrl_r <= RST_ZERO;
      buf_ch_pwr_r <= RST_ZERO;
      buf_ratio_r <= RST_ZERO;
      buf_sel_r <= RST_ZERO;
    end else if (reg_wr) begin
      case (reg_addr)
        ADDR_IN_CTRL: buf_in_ctrl_r <= reg_wdata & IN_CTRL_MASK;
        ADDR_CH_CYCLES: buf_ch_cyc_r <= reg_wdata;
        ADDR_CH_CTRL: buf_ch_ctrl_r <= reg_wdata;
        ADDR_CH_PWR: buf_ch_pwr_r <= reg_wdata & CH_PWR_MASK;
        ADDR_IN_RATIO: buf_ratio_r <= reg_wdata & RATIO_MASK;
        ADDR_IN_SEL: buf_sel_r <= reg_wdata & SEL_MASK;
        default: ;
      endcase
    end
  end

  // Self-clearing strobe; copy happens on the edge after the strobe write
  always_ff @(posedge clk) begin
    if (srst) begin
      update_r <= 1'b0;
    end else begin
      update_r <= reg_wr && (reg_addr == ADDR_UPDATE) && reg_wdata[UPDATE_B];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      act_in_ctrl_r <= RST_ZERO;
      act_ch_cyc_r <= RST_ZERO;
      act_ch_ctrl_r <= RST_ZERO;
      act_ch_pwr_r <= RST_ZERO;
      act_ratio_r <= RST_ZERO;
      act_sel_r <= RST_ZERO;
    end else if (update_r) begin
      act_in_ctrl_r <= buf_in_ctrl_r;
      act_ch_cyc_r <= buf_ch_cyc_r;
      act_ch_ctrl_r <= buf_ch_ctrl_r;
      act_ch_pwr_r <= buf_ch_pwr_r;
      act_ratio_r <= buf_ratio_r;
      act_sel_r <= buf_sel_r;
    end
  end

  // Reads return the buffers; the strobe and unmapped addresses read zero
  always_ff @(posedge clk) begin
    if (srst) begin
      reg_rdata <= RST_ZERO;
    end else if (reg_rd) begin
      case (reg_addr)
        ADDR_IN_CTRL: reg_rdata <= buf_in_ctrl_r;
        ADDR_CH_CYCLES: reg_rdata <= buf_ch_cyc_r;
        ADDR_CH_CTRL: reg_rdata <= buf_ch_ctrl_r;
        ADDR_CH_PWR: reg_rdata <= buf_ch_pwr_r;
        ADDR_IN_RATIO: reg_rdata <= buf_ratio_r;
        ADDR_IN_SEL: reg_rdata <= buf_sel_r;
        default: reg_rdata <= RST_ZERO;
      endcase
    end
  end

  // Pin synchronisers; only the second stage feeds logic
  always_ff @(posedge clk) begin
    if (srst) begin
      ext_s1_r <= 1'b0;
      ext_s2_r <= 1'b0;
      osc_s1_r <= 1'b0;
      osc_s2_r <= 1'b0;
      align_s1_r <= 1'b1;
      align_s2_r <= 1'b1;
    end else begin
      ext_s1_r <= ext_clk_pin;
      ext_s2_r <= ext_s1_r;
      osc_s1_r <= osc_clk_pin;
      osc_s2_r <= osc_s1_r;
      align_s1_r <= align_n_pin;
      align_s2_r <= align_s1_r;
    end
  end

  // Delayed copies of the synchronised sources for rising-edge detection
  always_ff @(posedge clk) begin
    if (srst) begin
      ext_d_r <= 1'b0;
      osc_d_r <= 1'b0;
    end else begin
      ext_d_r <= ext_s2_r;
      osc_d_r <= osc_s2_r;
    end
  end

  // Input section source and power
  assign in_pd = act_in_ctrl_r[IN_PD_ALL_B] || act_in_ctrl_r[IN_PD_SRC_B];
  assign sel_osc = act_in_ctrl_r[IN_SEL_OSC_B];
  // Oscillator source wins over a bypass request, so only the direct route passes the oscillator undivided
  assign in_bypass = (act_in_ctrl_r[IN_BYPASS_B] || (ratio == RATIO_BYPASS)) && !sel_osc;
  assign src_level = sel_osc ? (osc_s2_r && !act_in_ctrl_r[IN_PD_OSC_IF_B]) : ext_s2_r;
  // Limitation: sources must stay well below half the clk rate or edges are lost
  assign src_tick = !in_pd && (sel_osc ? (osc_s2_r && !osc_d_r && !act_in_ctrl_r[IN_PD_OSC_IF_B])
                                       : (ext_s2_r && !ext_d_r));

  // Ratio decode: high gets the extra cycle of odd ratios
  assign ratio = act_ratio_r[2:0];
  always_comb begin
    in_hi_m1 = CNT_0;
    in_lo_m1 = CNT_0;
    ratio_static = 1'b0;
    case (ratio)
      RATIO_DIV2: begin
        in_hi_m1 = CNT_0;
        in_lo_m1 = CNT_0;
      end
      RATIO_DIV3: begin
        in_hi_m1 = CNT_1;
        in_lo_m1 = CNT_0;
      end
      RATIO_DIV4: begin
        in_hi_m1 = CNT_1;
        in_lo_m1 = CNT_1;
      end
      RATIO_DIV5: begin
        in_hi_m1 = CNT_2;
        in_lo_m1 = CNT_1;
      end
      RATIO_DIV6: begin
        in_hi_m1 = CNT_2;
        in_lo_m1 = CNT_2;
      end
      RATIO_BYPASS: ratio_static = sel_osc; // Bypass refused with oscillator: held static
      default: ratio_static = 1'b1;
    endcase
  end

  // Input divider has no start level or phase offset of its own
  ccdiv_counter u_in_div (
    .clk(clk),
    .srst(srst),
    .tick(src_tick),
    .hold(in_pd || ratio_static),
    .start_hi(1'b0),
    .delay('0),
    .hi_m1(in_hi_m1),
    .lo_m1(in_lo_m1),
    .level_r(in_div_level)
  );

  // Channel divider input: input divider output or the source itself when bypassed
  assign div_in_level = in_pd ? 1'b0 : (in_bypass ? src_level : in_div_level);

  always_ff @(posedge clk) begin
    if (srst) begin
      div_in_d_r <= 1'b0;
    end else begin
      div_in_d_r <= div_in_level;
    end
  end

  // Channel divider advances once per rising edge of its input level
  assign ch_tick = div_in_level && !div_in_d_r;

  // Channel controls
  assign ch_bypass = act_ch_ctrl_r[CH_BYPASS_B];
  assign ch_ign = act_ch_ctrl_r[CH_IGN_ALIGN_B];
  assign ch_force = act_ch_ctrl_r[CH_FORCE_B];
  assign ch_start = act_ch_ctrl_r[CH_START_HI_B];
  assign ch_pd = act_ch_pwr_r[CH_PD_B];
  assign ch_direct = act_ch_pwr_r[CH_DIRECT_B];
  assign align_act = !align_s2_r && !ch_ign;

  // Static forcing is honoured only together with ignore-alignment
  always_comb begin
    if (ch_ign && ch_force) begin
      mode = CCDIV_STATIC;
    end else if (align_act) begin
      mode = CCDIV_HOLD;
    end else begin
      mode = CCDIV_RUN;
    end
  end

  assign ch_hold = (mode != CCDIV_RUN) || ch_bypass || ch_pd;

  ccdiv_counter u_ch_div (
    .clk(clk),
    .srst(srst),
    .tick(ch_tick),
    .hold(ch_hold),
    .start_hi(ch_start),
    .delay(act_ch_ctrl_r[CH_PHASE_LSB +: PHASE_W]),
    .hi_m1(act_ch_cyc_r[CYC_HI_LSB +: 4]),
    .lo_m1(act_ch_cyc_r[CYC_LO_LSB +: 4]),
    .level_r(ch_div_level)
  );

  // Direct routing is ignored when the select field chooses the divider path
  assign direct_active = ch_direct && ((act_sel_r[1:0] == SEL_OSC) || (act_sel_r[1:0] == SEL_EXT));
  assign direct_level = (act_sel_r[1:0] == SEL_OSC) ? osc_s2_r : ext_s2_r;

  // Channel output selection before the polarity stage
  // Direct route overrides bypass, and bypass overrides any forced or held level
  always_comb begin
    if (direct_active) begin
      out_nxt = direct_level;
    end else if (ch_bypass) begin
      out_nxt = div_in_level;
    end else begin
      case (mode)
        CCDIV_STATIC: out_nxt = ch_start;
        CCDIV_HOLD: out_nxt = 1'b0;
        CCDIV_RUN: out_nxt = ch_div_level;
        default: out_nxt = 1'b0;
      endcase
    end
  end

  // Outputs: power-down parks all three low regardless of polarity
  always_ff @(posedge clk) begin
    if (srst) begin
      channel3_output_a <= 1'b0;
      channel3_output_b <= 1'b0;
      channel3_output_c <= 1'b0;
    end else if (ch_pd) begin
      channel3_output_a <= 1'b0;
      channel3_output_b <= 1'b0;
      channel3_output_c <= 1'b0;
    end else begin
      channel3_output_a <= out_nxt ^ drv_invert;
      channel3_output_b <= out_nxt ^ drv_invert;
      channel3_output_c <= out_nxt ^ drv_invert;
    end
  end

  // Power and correction status
  always_ff @(posedge clk) begin
    if (srst) begin
      channel3_pd <= 1'b0;
      duty_cycle_correction <= 1'b1;
      channel3_div_pd <= 1'b0;
      clk_in_section_pd <= 1'b0;
      osc_if_pd <= 1'b0;
      osc_and_clk_pd <= 1'b0;
    end else begin
      channel3_pd <= ch_pd;
      duty_cycle_correction <= !act_ch_pwr_r[CH_DCC_OFF_B];
      channel3_div_pd <= ch_pd || ch_bypass || direct_active;
      clk_in_section_pd <= act_in_ctrl_r[IN_PD_ALL_B];
      osc_if_pd <= act_in_ctrl_r[IN_PD_OSC_IF_B];
      osc_and_clk_pd <= act_in_ctrl_r[IN_PD_SRC_B];
    end
  end
endmodule : ccdiv_ctrl

// ---- bench/ccdiv_ctrl_props.sv ----
// Checker of port behaviour for the channel 3 and input divider control
`timescale 1ns/100ps
module ccdiv_ctrl_props
  import ccdiv_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // Pins
  input wire logic align_n_pin,
  input wire logic drv_invert,
  // Outputs
  input wire logic channel3_output_a,
  input wire logic channel3_output_b,
  input wire logic channel3_output_c,
  input wire logic channel3_pd,
  input wire logic duty_cycle_correction,
  input wire logic channel3_div_pd,
  input wire logic clk_in_section_pd,
  input wire logic osc_if_pd,
  input wire logic osc_and_clk_pd
);
  logic [7:0] in_r, ctl_r, pw_r, ctl_act_r, pw_act_r;
  logic [2:0] upd_cnt_r;
  logic upd, settled;
  assign upd = reg_wr && reg_addr == ADDR_UPDATE && reg_wdata[UPDATE_B];
  // Only judge the divider path once no update is in flight and nothing else owns the pins
  assign settled = upd_cnt_r == 3'h7 && !pw_act_r[CH_PD_B] && !pw_act_r[CH_DIRECT_B] && !ctl_act_r[CH_BYPASS_B];
  always_ff @(posedge clk) begin
    if (srst) begin
      in_r <= RST_ZERO;
      ctl_r <= RST_ZERO;
      pw_r <= RST_ZERO;
    end else if (reg_wr && reg_addr == ADDR_IN_CTRL) begin
      in_r <= reg_wdata;
    end else if (reg_wr && reg_addr == ADDR_CH_CTRL) begin
      ctl_r <= reg_wdata;
    end else if (reg_wr && reg_addr == ADDR_CH_PWR) begin
      pw_r <= reg_wdata;
    end
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      ctl_act_r <= RST_ZERO;
      pw_act_r <= RST_ZERO;
      upd_cnt_r <= 3'h7;
    end else if (upd) begin
      ctl_act_r <= ctl_r;
      pw_act_r <= pw_r;
      upd_cnt_r <= 3'h0;
    end else if (upd_cnt_r != 3'h7) begin
      upd_cnt_r <= upd_cnt_r + 3'h1;
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  sequence s_upd;
    upd;
  endsequence
  sequence s_held;
    !align_n_pin [*6];
  endsequence
  AST_RST: assert property ($past(srst) |-> !channel3_output_a && !channel3_pd && duty_cycle_correction)
    else $error("outputs wrong after reset");
  AST_SAME: assert property (channel3_output_a == channel3_output_b && channel3_output_b == channel3_output_c)
    else $error("channel outputs differ");
  AST_PD: assert property (channel3_pd && $past(channel3_pd) |-> !channel3_output_a && channel3_div_pd)
    else $error("powered down channel still drives");
  AST_UPD_ONLY: assert property ($changed({channel3_pd, duty_cycle_correction, clk_in_section_pd, osc_if_pd,
    osc_and_clk_pd}) |-> upd_cnt_r <= 3'h5)
    else $error("status changed without update");
  AST_IN_PD: assert property (s_upd |-> ##[3:5] {clk_in_section_pd, osc_if_pd, osc_and_clk_pd} == in_r[4:2])
    else $error("input power status not applied");
  AST_CH_PWR: assert property (s_upd |-> ##[3:5] channel3_pd == pw_r[CH_PD_B] && duty_cycle_correction == !pw_r[0])
    else $error("channel power status not applied");
  AST_ALIGN: assert property (s_held ##0 (settled && !ctl_act_r[CH_IGN_ALIGN_B] && drv_invert == $past(drv_invert, 2))
    |-> channel3_output_a == drv_invert)
    else $error("obeying divider not held during alignment");
  AST_FORCE: assert property (settled && ctl_act_r[CH_IGN_ALIGN_B] && ctl_act_r[CH_FORCE_B]
    && drv_invert == $past(drv_invert, 2) |-> channel3_output_a == (ctl_act_r[CH_START_HI_B] ^ drv_invert))
    else $error("forced level wrong");
  AST_UPD_READ: assert property (reg_rd && reg_addr == ADDR_UPDATE |=> reg_rdata == 8'h00)
    else $error("update register reads nonzero");
endmodule : ccdiv_ctrl_props

bind ccdiv_ctrl ccdiv_ctrl_props u_props (.clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .align_n_pin, .drv_invert, .channel3_output_a, .channel3_output_b, .channel3_output_c, .channel3_pd,
  .duty_cycle_correction, .channel3_div_pd, .clk_in_section_pd, .osc_if_pd, .osc_and_clk_pd);

// ---- bench/test_ccdiv_ctrl.sv ----
// Self-checking bench for the channel 3 and input divider control
`timescale 1ns/100ps
module test_ccdiv_ctrl
  import ccdiv_pkg::*;
;
  logic clk, srst, reg_wr, reg_rd, ext_clk_pin, osc_clk_pin, align_n_pin, drv_invert;
  logic [ADDR_W-1:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  logic out_a, ch_pd, dcc, div_pd, in_pd, osc_pd, src_pd;
  int err_count, checks, cyc;
  int c [8];
  ccdiv_ctrl uut (.clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_clk_pin(ext_clk_pin), .osc_clk_pin(osc_clk_pin),
    .align_n_pin(align_n_pin), .drv_invert(drv_invert), .channel3_output_a(out_a), .channel3_output_b(),
    .channel3_output_c(), .channel3_pd(ch_pd), .duty_cycle_correction(dcc), .channel3_div_pd(div_pd),
    .clk_in_section_pd(in_pd), .osc_if_pd(osc_pd), .osc_and_clk_pd(src_pd));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Sources slow enough that every edge survives the synchroniser
  always @(negedge clk) begin
    cyc++;
    if (srst) begin
      ext_clk_pin <= 1'b0;
      osc_clk_pin <= 1'b0;
    end else begin
      if (cyc % 3 == 0) ext_clk_pin <= ~ext_clk_pin;
      if (cyc % 5 == 0) osc_clk_pin <= ~osc_clk_pin;
    end
    if (cyc == 40000) begin
      err_count++;
      results();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic chk_n(input int n, input int lo, input int hi);
    checks++;
    if (n < lo || n > hi) begin
      err_count++;
      $display("CHECK FAILED at %0t: count %0d outside %0d..%0d", $time, n, lo, hi);
    end
  endtask : chk_n
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] e);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    chk(reg_rdata, e);
  endtask : rd
  task automatic apply(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    wr(a, d);
    wr(ADDR_UPDATE, 8'h01);
    repeat (8) @(negedge clk);
  endtask : apply
  // Output transitions over a fixed window of 480 cycles
  task automatic tog(output int n);
    logic p;
    n = 0;
    p = out_a;
    repeat (480) begin
      @(negedge clk);
      if (out_a !== p) n++;
      p = out_a;
    end
  endtask : tog
  task automatic first(output int n);
    logic p;
    n = 0;
    p = out_a;
    while (out_a === p && n < 400) begin
      @(negedge clk);
      n++;
    end
  endtask : first
  task automatic t_regs;
    logic [ADDR_W-1:0] ad [6] = '{ADDR_IN_CTRL, ADDR_CH_CYCLES, ADDR_CH_CTRL, ADDR_CH_PWR, ADDR_IN_RATIO, ADDR_IN_SEL};
    logic [7:0] mk [6] = '{8'h1f, 8'hff, 8'hff, 8'h07, 8'h07, 8'h03};
    chk({7'h0, dcc}, 8'h01);
    rd(ADDR_UPDATE, 8'h00);
    for (int k = 0; k < 6; k++) begin
      rd(ad[k], 8'h00);
      wr(ad[k], 8'hff);
      rd(ad[k], mk[k]);
      wr(ad[k], 8'h00);
    end
    wr(10'h3ff, 8'hff);
    rd(10'h3ff, 8'h00);
  endtask : t_regs
  task automatic t_inpd;
    int n;
    wr(ADDR_IN_CTRL, 8'h1c);
    repeat (8) @(negedge clk);
    chk({5'h0, in_pd, osc_pd, src_pd}, 8'h00);
    apply(ADDR_UPDATE, 8'h01);
    chk({5'h0, in_pd, osc_pd, src_pd}, 8'h07);
    tog(n);
    chk_n(n, 0, 0);
    apply(ADDR_IN_CTRL, 8'h00);
  endtask : t_inpd
  task automatic t_chpd;
    int n;
    apply(ADDR_CH_PWR, 8'h05);
    chk({5'h0, ch_pd, dcc, div_pd}, 8'h05);
    tog(n);
    chk_n(n, 0, 0);
    apply(ADDR_CH_PWR, 8'h00);
  endtask : t_chpd
  task automatic t_ratio;
    int n;
    for (int k = 0; k < 8; k++) begin
      apply(ADDR_IN_RATIO, 8'(k));
      tog(c[k]);
    end
    chk_n(c[5] + c[7], 0, 0);
    for (int k = 0; k < 4; k++) chk_n(c[k + 1], 1, c[k] - 1);
    chk_n(c[6], c[0] + 1, 999);
    wr(ADDR_IN_RATIO, 8'h06);
    apply(ADDR_IN_CTRL, 8'h02);
    tog(n);
    chk_n(n, 0, 0);
    apply(ADDR_IN_RATIO, 8'h00);
    tog(c[5]);
    chk_n(c[5], 1, c[0] - 1);
    apply(ADDR_IN_CTRL, 8'h03);
    tog(n);
    chk_n(n, c[5] - 2, c[5] + 2);
    apply(ADDR_IN_CTRL, 8'h0a);
    tog(n);
    chk_n(n, 0, 0);
    apply(ADDR_IN_CTRL, 8'h01);
    tog(n);
    chk_n(n, c[0] + 1, 999);
    apply(ADDR_IN_CTRL, 8'h00);
  endtask : t_ratio
  task automatic t_align;
    int n, h0, h4;
    apply(ADDR_CH_CTRL, 8'h10);
    align_n_pin = 1'b0;
    repeat (8) @(negedge clk);
    tog(n);
    chk_n(n, 0, 0);
    drv_invert = 1'b1;
    repeat (4) @(negedge clk);
    chk({7'h0, out_a}, 8'h01);
    drv_invert = 1'b0;
    repeat (4) @(negedge clk);
    align_n_pin = 1'b1;
    first(n);
    chk({7'h0, out_a}, 8'h01);
    first(h0);
    align_n_pin = 1'b0;
    apply(ADDR_CH_CTRL, 8'h14);
    align_n_pin = 1'b1;
    first(n);
    first(h4);
    chk_n(h4, h0 + 30, h0 + 70);
    align_n_pin = 1'b0;
    apply(ADDR_CH_CTRL, 8'h40);
    tog(n);
    chk_n(n, 1, 999);
    align_n_pin = 1'b1;
  endtask : t_align
  task automatic t_force;
    int n;
    apply(ADDR_CH_CTRL, 8'h70);
    tog(n);
    chk_n(n, 0, 0);
    chk({7'h0, out_a}, 8'h01);
    apply(ADDR_CH_CTRL, 8'h60);
    chk({7'h0, out_a}, 8'h00);
    apply(ADDR_CH_CTRL, 8'h30);
    tog(n);
    chk_n(n, 1, 999);
    apply(ADDR_CH_CTRL, 8'hb0);
    tog(n);
    chk_n(n, c[0] + 1, 999);
    chk({7'h0, div_pd}, 8'h01);
    apply(ADDR_CH_CTRL, 8'h00);
  endtask : t_force
  task automatic t_direct;
    int n;
    apply(ADDR_CH_PWR, 8'h02);
    tog(n);
    chk_n(n, 150, 170);
    chk({7'h0, div_pd}, 8'h01);
    apply(ADDR_IN_SEL, 8'h01);
    tog(n);
    chk_n(n, c[0] - 2, c[0] + 2);
    apply(ADDR_IN_SEL, 8'h02);
    tog(n);
    chk_n(n, 86, 106);
  endtask : t_direct
  task automatic results;
    $display("Checks %0d, mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : results
  initial begin
    {reg_wr, reg_rd, drv_invert} = '0;
    align_n_pin = 1'b1;
    reg_addr = '0;
    reg_wdata = '0;
    srst = 1'b1;
    repeat (2) @(negedge clk);
    srst = 1'b0;
    t_regs();
    t_inpd();
    t_chpd();
    t_ratio();
    t_align();
    t_force();
    t_direct();
    results();
  end
endmodule : test_ccdiv_ctrl
